/* File: core/eifs_decoder.sv */
// Skip-test decoder for the two external interrupt request flags.
// Assumes the sequencer presents one opcode per cycle with a valid strobe
// and turns skip_out into a NOP slot for the following instruction.
module eifs_decoder (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic instr_valid_in,
  input wire logic [9:0] instr_in,
  input wire logic ext0_edge_in,
  input wire logic ext1_edge_in,
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic skip_out,
  output logic suppress_out,
  output logic ext0_request_flag_out,
  output logic ext1_request_flag_out,
  output logic irq_out
);
  import eifs_pkg::*;

  // Whole state of the block in one record
  typedef struct packed {
    eifs_bus_state_t bus;
    logic [31:0] rdata;
    logic wait_n;
    logic [3:0] intr_control_reg_one;
    logic [1:0] flags;
    logic [2:0] stat;
    logic [2:0] mask;
    logic skip;
    logic suppress;
    logic irq;
  } eifs_state_t;

  eifs_state_t st;
  eifs_state_t next_st;

  // Decode and skip decision
  logic is_t0;
  logic is_t1;
  logic en0;
  logic en1;
  logic skip0;
  logic skip1;
  logic live;

  always_comb begin
    // A suppressed slot executes nothing, including another test
    live = instr_valid_in && !st.suppress;
    is_t0 = live && (instr_in == EIFS_OP_EXT0);
    is_t1 = live && (instr_in == EIFS_OP_EXT1);
    en0 = st.intr_control_reg_one[EIFS_EN0_BIT];
    en1 = st.intr_control_reg_one[EIFS_EN1_BIT];
    // Set flag with its interrupt enable clear turns the test into a skip
    skip0 = is_t0 && !en0 && st.flags[EIFS_F0_BIT];
    skip1 = is_t1 && !en1 && st.flags[EIFS_F1_BIT];
  end

  // Next-state logic for bus, flags and interrupt
  always_comb begin
    next_st = st;
    next_st.skip = skip0 || skip1;
    // Suppress only counts valid slots, so stalls keep the pending skip
    if (skip0 || skip1) begin
      next_st.suppress = 1'b1;
    end else if (instr_valid_in) begin
      next_st.suppress = 1'b0;
    end
    // Bus slave: one cycle of wait, answer in the second
    case (st.bus)
      EIFS_BUS_IDLE: begin
        next_st.wait_n = 1'b0;
        if (avs_read_in || avs_write_in) begin
          next_st.bus = EIFS_BUS_ANSWER;
          next_st.wait_n = 1'b1;
          next_st.rdata = 32'h0;
          case (avs_address_in[3:2])
            EIFS_REG_CTRL: next_st.rdata[3:0] = st.intr_control_reg_one;
            EIFS_REG_FLAG: next_st.rdata[1:0] = st.flags;
            EIFS_REG_STAT: next_st.rdata[2:0] = st.stat;
            EIFS_REG_MASK: next_st.rdata[2:0] = st.mask;
            default: next_st.rdata = 32'h0;
          endcase
        end
      end
      EIFS_BUS_ANSWER: begin
        next_st.bus = EIFS_BUS_IDLE;
        next_st.wait_n = 1'b0;
        // Write lands at the edge where the master sees waitrequest low
        if (avs_write_in) begin
          case (avs_address_in[3:2])
            EIFS_REG_CTRL: next_st.intr_control_reg_one = avs_writedata_in[3:0];
            EIFS_REG_FLAG: next_st.flags = avs_writedata_in[1:0];
            EIFS_REG_STAT: next_st.stat = st.stat & ~avs_writedata_in[2:0];
            EIFS_REG_MASK: next_st.mask = avs_writedata_in[2:0];
            default: next_st.mask = st.mask;
          endcase
        end
      end
      default: begin
        next_st.bus = EIFS_BUS_IDLE;
        next_st.wait_n = 1'b0;
      end
    endcase
    // Skip clears its flag; an edge in the same cycle wins
    if (skip0) begin
      next_st.flags[EIFS_F0_BIT] = 1'b0;
    end
    if (skip1) begin
      next_st.flags[EIFS_F1_BIT] = 1'b0;
    end
    if (ext0_edge_in) begin
      next_st.flags[EIFS_F0_BIT] = 1'b1;
      next_st.stat[EIFS_F0_BIT] = 1'b1;
    end
    if (ext1_edge_in) begin
      next_st.flags[EIFS_F1_BIT] = 1'b1;
      next_st.stat[EIFS_F1_BIT] = 1'b1;
    end
    if (skip0 || skip1) begin
      next_st.stat[EIFS_SKIP_BIT] = 1'b1;
    end
    next_st.irq = |(next_st.stat & next_st.mask);
  end

  // Register the whole state
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      st.bus <= EIFS_BUS_IDLE;
      st.rdata <= 32'h0;
      st.wait_n <= 1'b0;
      st.intr_control_reg_one <= EIFS_CTRL_RST;
      st.flags <= EIFS_FLAG_RST;
      st.stat <= EIFS_IRQ_RST;
      st.mask <= EIFS_IRQ_RST;
      st.skip <= 1'b0;
      st.suppress <= 1'b0;
      st.irq <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from flip-flops, except waitrequest, which also decodes avs_read_in and avs_write_in
  assign avs_readdata_out = st.rdata;
  assign avs_waitrequest_out = !st.wait_n && (avs_read_in || avs_write_in) ? 1'b1 : 1'b0;
  assign skip_out = st.skip;
  assign suppress_out = st.suppress;
  assign ext0_request_flag_out = st.flags[EIFS_F0_BIT];
  assign ext1_request_flag_out = st.flags[EIFS_F1_BIT];
  assign irq_out = st.irq;
endmodule // eifs_decoder

/* File: core/eifs_pkg.sv */
// Constants for the external interrupt flag skip-test decoder.
// Assumes one system clock, synchronous active-low reset, Avalon-MM register access.
package eifs_pkg;
  // Opcodes of the two flag tests
  localparam logic [9:0] EIFS_OP_EXT0 = 10'h038;
  localparam logic [9:0] EIFS_OP_EXT1 = 10'h039;
  // Bit positions of the enables in control register one
  localparam int EIFS_EN0_BIT = 0;
  localparam int EIFS_EN1_BIT = 1;
  // Bit positions in the request flag and interrupt registers
  localparam int EIFS_F0_BIT = 0;
  localparam int EIFS_F1_BIT = 1;
  localparam int EIFS_SKIP_BIT = 2;
  // Register word offsets (byte address bits 3:2)
  localparam logic [1:0] EIFS_REG_CTRL = 2'h0;
  localparam logic [1:0] EIFS_REG_FLAG = 2'h1;
  localparam logic [1:0] EIFS_REG_STAT = 2'h2;
  localparam logic [1:0] EIFS_REG_MASK = 2'h3;
  // Reset values
  localparam logic [3:0] EIFS_CTRL_RST = 4'h0;
  localparam logic [1:0] EIFS_FLAG_RST = 2'h0;
  localparam logic [2:0] EIFS_IRQ_RST = 3'h0;
  // Bus handshake states, Gray along idle-answer
  typedef enum logic [1:0] {
    EIFS_BUS_IDLE = 2'b00,
    EIFS_BUS_ANSWER = 2'b01
  } eifs_bus_state_t;
endpackage

/* File: verification/eifs_monitor.sv */
// Port checker for the skip-test decoder.
// Assumes a bind onto eifs_decoder.
module eifs_monitor import eifs_pkg::*; (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic instr_valid_in,
  input wire logic [9:0] instr_in,
  input wire logic ext0_edge_in,
  input wire logic ext1_edge_in,
  input wire logic avs_write_in,
  input wire logic skip_out,
  input wire logic suppress_out,
  input wire logic ext0_request_flag_out,
  input wire logic ext1_request_flag_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  // Taken test slots
  sequence s_t0; instr_valid_in && !suppress_out && instr_in == EIFS_OP_EXT0; endsequence
  sequence s_t1; instr_valid_in && !suppress_out && instr_in == EIFS_OP_EXT1; endsequence
  a_skip_has_cause: assert property (skip_out |-> $past(instr_valid_in && !suppress_out &&
    (instr_in == EIFS_OP_EXT0 && ext0_request_flag_out || instr_in == EIFS_OP_EXT1 && ext1_request_flag_out)))
    else $error("bad skip");
  a_skip_clears_f0: assert property (s_t0 ##0 !ext0_edge_in && !avs_write_in ##1 skip_out |-> !ext0_request_flag_out)
    else $error("flag0 kept");
  a_skip_clears_f1: assert property (s_t1 ##0 !ext1_edge_in && !avs_write_in ##1 skip_out |-> !ext1_request_flag_out)
    else $error("flag1 kept");
  a_no_flag_run: assert property (s_t0 ##0 !ext0_request_flag_out |=> !skip_out) else $error("skip on 0");
  a_skip_marks_nop: assert property (skip_out |-> suppress_out) else $error("no nop");
  a_nop_slot_quiet: assert property (suppress_out && instr_valid_in |=> !skip_out && !suppress_out)
    else $error("nop slot");
  a_nop_waits_slot: assert property (suppress_out && !instr_valid_in |=> suppress_out) else $error("nop lost");
  a_skip_one_pulse: assert property (skip_out |=> !skip_out) else $error("long skip");
endmodule // eifs_monitor

/* File: verification/eifs_decoder_test.sv */
// Random and corner runs of both flag tests.
// Assumes eifs_decoder and eifs_monitor are compiled first.
module eifs_decoder_test import eifs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_in = 0, rst_b_in = 0, instr_valid_in = 0, ext0_edge_in = 0, ext1_edge_in = 0;
  logic avs_read_in = 0, avs_write_in = 0, avs_waitrequest_out, skip_out, suppress_out, irq_out;
  logic ext0_request_flag_out, ext1_request_flag_out;
  logic [9:0] instr_in = 0;
  logic [3:0] avs_address_in = 0;
  logic [31:0] avs_writedata_in = 0, avs_readdata_out, q;
  logic [7:0] v;
  int n_errors = 0, n_compared = 0;
  eifs_decoder dut (.*);
  always #25 clk_sys_in = ~clk_sys_in;
  // Skip expected when enable clear and flag set
  function logic sk(logic [7:0] x);
    return !x[2] && x[1];
  endfunction
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  // One Avalon transfer; waits as long as waitrequest says
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    avs_address_in <= a;
    avs_write_in <= w;
    avs_read_in <= !w;
    avs_writedata_in <= d;
    do @(posedge clk_sys_in); while (avs_waitrequest_out !== 1'b0);
    q = avs_readdata_out;
    avs_read_in <= 0;
    avs_write_in <= 0;
  endtask
  task complete_run;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // First eight runs walk every test, enable and flag corner
  initial begin
    void'($urandom(83737));
    repeat (12) @(posedge clk_sys_in);
    rst_b_in <= 1;
    for (int i = 0; i < 40; i++) begin
      v = (i < 8) ? 8'(i) : 8'($urandom);
      bus(1, 4'h0, {30'h0, v[0] ? {v[2], v[3]} : {v[3], v[2]}});
      bus(1, 4'hC, {29'h0, v[6:4]});
      bus(1, 4'h8, 32'h7);
      bus(1, 4'h4, 32'h0);
      bus(0, 4'h0, 0);
      chk(q, {30'h0, v[0] ? {v[2], v[3]} : {v[3], v[2]}});
      ext0_edge_in <= v[1] && !v[0];
      ext1_edge_in <= v[1] && v[0];
      @(posedge clk_sys_in);
      ext0_edge_in <= 0;
      ext1_edge_in <= 0;
      instr_valid_in <= 1;
      instr_in <= v[0] ? EIFS_OP_EXT1 : EIFS_OP_EXT0;
      @(posedge clk_sys_in);
      instr_in <= v[0] ? EIFS_OP_EXT0 : EIFS_OP_EXT1;
      #1 chk({skip_out, suppress_out}, {2{sk(v)}});
      chk({ext1_request_flag_out, ext0_request_flag_out}, {v[0] & v[1] & !sk(v), !v[0] & v[1] & !sk(v)});
      @(posedge clk_sys_in);
      instr_valid_in <= 0;
      #1 chk({skip_out, suppress_out}, 0);
      chk(irq_out, |(v[6:4] & {sk(v), v[1] & v[0], v[1] & !v[0]}));
      $display("test %0d done", i);
    end
    complete_run;
  end
  // Run needs about 730 cycles
  initial begin
    repeat (5000) @(posedge clk_sys_in);
    n_errors++;
    complete_run;
  end
endmodule // eifs_decoder_test
bind eifs_decoder eifs_monitor mon (.*);
